// [verilog/scs_pkg.sv]
// constants shared by the sync clock select block and its testbench
// assumes a single 10 MHz reference clock and an AXI4-Lite register bus
package scs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FREQ     = 8'h04;
  localparam logic [7:0] ADDR_STAT     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_BAUD     = 8'h14;
  // control field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_OUT_BIT = 1;
  localparam int CTRL_DIV_LSB = 4;
  localparam int DIV_EXP_W    = 4;
  // status field positions
  localparam int STAT_EXT_BIT  = 0;
  localparam int STAT_DEAD_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  // interrupt bit positions
  localparam int IRQ_FALLBACK_BIT = 0;
  localparam int IRQ_LOCK_BIT     = 1;
  localparam int IRQ_RECONF_BIT   = 2;
  localparam int IRQ_W            = 3;
  // operating frequency in kHz, reset is the internal oscillator rate
  localparam int FREQ_W = 20;
  localparam logic [FREQ_W-1:0] FREQ_RST = 20'h03E1C;
  localparam logic [DIV_EXP_W-1:0] DIV_EXP_RST = 4'h1;
  // serial port divisor is derived from the operating frequency
  localparam int KHZ_HZ    = 1000;
  localparam int BAUD_RATE = 115200;
  localparam int BAUD_W    = 16;
  localparam logic [BAUD_W-1:0] BAUD_RST =
    BAUD_W'(int'(FREQ_RST) * KHZ_HZ / BAUD_RATE);
  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int EXT_TIMEOUT_NS  = 10000;
  localparam int EXT_TIMEOUT_CYC =
    (EXT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_EDGES   = 4;
  localparam int INT_TICK_DIV = 2;
  localparam int OUT_CNT_W    = 16;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock source in use
  typedef enum logic [0:0] {SRC_INT, SRC_EXT} scs_src_t;
endpackage

// [verilog/scs_div_if.sv]
// request and answer lines between the block and its divisor calculator
// assumes both ends sit on the same reference clock
`timescale 1ns/1ps
`default_nettype none
interface scs_div_if;
  logic        start;     // one-cycle request, restarts any run
  logic [31:0] dividend;  // held stable while busy
  logic [31:0] divisor;   // held stable while busy
  logic        busy;      // calculation running
  logic        done;      // one-cycle pulse, quotient valid
  logic [31:0] quotient;  // result, held until next done
  modport req  (output start, dividend, divisor,
                input  busy, done, quotient);
  modport calc (input  start, dividend, divisor,
                output busy, done, quotient);
endinterface
`default_nettype wire

// [verilog/scs_div.sv]
// serial restoring divider, one quotient bit per clock
// assumes divisor is nonzero; dividend and divisor are captured at start
`timescale 1ns/1ps
`default_nettype none
module scs_div #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // request side
  scs_div_if.calc   div_bus
);
  localparam int SW = $clog2(W);
  localparam logic [SW-1:0] STEP_LAST = SW'(W - 1);

  typedef enum logic [0:0] {SCS_DIV_IDLE, SCS_DIV_RUN} scs_div_state_t;

  scs_div_state_t state;  // idle or running
  logic [SW-1:0]  step;   // bit being produced
  logic [W-1:0]   rem;    // partial remainder
  logic [W-1:0]   quo;    // dividend shifting into quotient
  logic [W-1:0]   dvs;    // captured divisor
  wire  [W:0]     rem_sh; // remainder with next dividend bit
  wire            fits;   // divisor fits, quotient bit is one
  wire  [W:0]     rem_sub;

  assign rem_sh  = {rem, quo[W-1]};
  assign fits    = rem_sh >= {1'b0, dvs};
  assign rem_sub = rem_sh - {1'b0, dvs};

  // a new start aborts a run so the latest frequency always wins
  always_ff @(posedge ref_clk_i) begin
    div_bus.done <= 1'b0;
    if (!rst_b_i) begin
      state            <= SCS_DIV_IDLE;
      step             <= '0;
      rem              <= '0;
      quo              <= '0;
      dvs              <= '0;
      div_bus.busy     <= 1'b0;
      div_bus.quotient <= '0;
    end else if (div_bus.start) begin
      state        <= SCS_DIV_RUN;
      step         <= '0;
      rem          <= '0;
      quo          <= div_bus.dividend;
      dvs          <= div_bus.divisor;
      div_bus.busy <= 1'b1;
    end else begin
      unique case (state)
        SCS_DIV_IDLE: begin
        end
        SCS_DIV_RUN: begin
          rem  <= fits ? rem_sub[W-1:0] : rem_sh[W-1:0];
          quo  <= {quo[W-2:0], fits};
          step <= step + 1'b1;
          // last bit: publish and go idle
          if (step == STEP_LAST) begin
            state            <= SCS_DIV_IDLE;
            div_bus.busy     <= 1'b0;
            div_bus.done     <= 1'b1;
            div_bus.quotient <= {quo[W-2:0], fits};
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verilog/scs_top.sv]
// supervisor clock source select with sync line input/output and
// AXI4-Lite registers
// assumes the sync pin is asynchronous and the bus runs on ref_clk_i
//
// Summary of operation
// R1: run on internal oscillator unless ext selected
// R2: external mode takes clock from sync input
// R3: selected source paces controller and logic ticks
// R4: ext signal stops, fall back to internal
// R5: odd ext frequency needs frequency command
// R6: frequency command recomputes serial port divisor
// R7: sync input and output functions exclude
// R8: output drives internal clock over power-of-two
// R9: output enable and divider set by command
// R10: sync line is shared, bidirectional
// R11: edge timeout declares failure, clean switch back
`timescale 1ns/1ps
`default_nettype none
module scs_top #(
  parameter int TIMEOUT_CYC = scs_pkg::EXT_TIMEOUT_CYC,
  parameter int LOCK_EDGES  = scs_pkg::LOCK_EDGES,
  parameter int TICK_DIV    = scs_pkg::INT_TICK_DIV
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // shared sync line
  input  wire logic        sync_i,
  output logic             sync_o,
  output logic             sync_oe_o,
  // clock pacing for controller and companion logic
  output logic             sup_tick_o,
  output logic             logic_tick_o,
  output logic             clk_src_ext_o,
  output logic [15:0]      baud_div_o,
  // interrupt
  output logic             irq_o
);
  localparam int IDLE_W = $clog2(TIMEOUT_CYC + 1);
  localparam int GOOD_W = $clog2(LOCK_EDGES + 1);
  localparam int TICK_W = $clog2(TICK_DIV + 1);
  localparam logic [IDLE_W-1:0] IDLE_MAX  = IDLE_W'(TIMEOUT_CYC);
  localparam logic [GOOD_W-1:0] GOOD_MAX  = GOOD_W'(LOCK_EDGES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  localparam int IW = scs_pkg::IRQ_W;
  localparam int DW = scs_pkg::DIV_EXP_W;
  localparam int FW = scs_pkg::FREQ_W;
  localparam int CW = scs_pkg::OUT_CNT_W;

  // bus state
  logic        aw_got;   // write address captured
  logic        w_got;    // write data captured
  logic [7:0]  awaddr_q; // captured write address
  logic [31:0] wdata_q;  // captured write data
  logic [3:0]  wstrb_q;  // captured byte strobes
  // software registers
  logic          ext_sel;   // input function chosen
  logic          out_en;    // output function chosen
  logic [DW-1:0] div_exp;   // output divide exponent
  logic [FW-1:0] freq_khz;  // operating frequency
  logic [IW-1:0] irq_stat;  // sticky events
  logic [IW-1:0] irq_mask;  // interrupt enables
  // sync input path
  logic sync_q1;  // first synchroniser stage, read only by q2
  logic sync_q2;  // synchronised level
  logic sync_q3;  // delayed for edge detect
  logic [IDLE_W-1:0] idle_cnt;  // cycles since last edge
  logic [GOOD_W-1:0] good_cnt;  // edges seen since alive
  scs_pkg::scs_src_t src;       // source in use
  logic [TICK_W-1:0] tick_cnt;  // internal tick prescaler
  logic [CW-1:0]     out_cnt;   // free running output divider
  logic              div_start; // divisor request pulse

  scs_div_if div_bus ();

  // divisor calculator
  scs_div #(
    .W (32)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .div_bus   (div_bus)
  );

  // handshakes and decode
  wire aw_hs   = s_axi_awvalid_i & s_axi_awready_o;
  wire w_hs    = s_axi_wvalid_i & s_axi_wready_o;
  wire b_hs    = s_axi_bvalid_o & s_axi_bready_i;
  wire ar_hs   = s_axi_arvalid_i & s_axi_arready_o;
  wire r_hs    = s_axi_rvalid_o & s_axi_rready_i;
  wire wr_fire = aw_got & w_got & ~s_axi_bvalid_o;
  wire wr_ctrl = wr_fire & (awaddr_q == scs_pkg::ADDR_CTRL);
  wire wr_freq = wr_fire & (awaddr_q == scs_pkg::ADDR_FREQ);
  wire wr_ist  = wr_fire & (awaddr_q == scs_pkg::ADDR_IRQ_STAT);
  wire wr_imsk = wr_fire & (awaddr_q == scs_pkg::ADDR_IRQ_MASK);
  wire wr_hit  = (awaddr_q == scs_pkg::ADDR_CTRL) |
                 (awaddr_q == scs_pkg::ADDR_FREQ) |
                 (awaddr_q == scs_pkg::ADDR_STAT) |
                 (awaddr_q == scs_pkg::ADDR_IRQ_STAT) |
                 (awaddr_q == scs_pkg::ADDR_IRQ_MASK) |
                 (awaddr_q == scs_pkg::ADDR_BAUD);

  // byte lane merge of the write data
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] ctrl_word = {24'h000000, div_exp, 2'h0, out_en, ext_sel};
  wire [31:0] ctrl_new  = (ctrl_word & ~wmask) | (wdata_q & wmask);
  wire [31:0] freq_new  = ({12'h000, freq_khz} & ~wmask) |
                          (wdata_q & wmask);
  wire [31:0] mask_new  = ({29'h0, irq_mask} & ~wmask) |
                          (wdata_q & wmask);
  wire [IW-1:0] irq_clr = wr_ist ? (wdata_q[IW-1:0] & wmask[IW-1:0])
                                 : '0;

  // read mux
  wire ext_dead = idle_cnt == IDLE_MAX;
  wire [31:0] stat_word = {29'h0, div_bus.busy, ext_dead,
                           src == scs_pkg::SRC_EXT};
  wire rd_ctrl = s_axi_araddr_i == scs_pkg::ADDR_CTRL;
  wire rd_freq = s_axi_araddr_i == scs_pkg::ADDR_FREQ;
  wire rd_stat = s_axi_araddr_i == scs_pkg::ADDR_STAT;
  wire rd_ist  = s_axi_araddr_i == scs_pkg::ADDR_IRQ_STAT;
  wire rd_imsk = s_axi_araddr_i == scs_pkg::ADDR_IRQ_MASK;
  wire rd_baud = s_axi_araddr_i == scs_pkg::ADDR_BAUD;
  wire rd_hit  = rd_ctrl | rd_freq | rd_stat | rd_ist | rd_imsk | rd_baud;
  wire [31:0] rd_data =
    rd_ctrl ? ctrl_word :
    rd_freq ? {12'h000, freq_khz} :
    rd_stat ? stat_word :
    rd_ist  ? {29'h0, irq_stat} :
    rd_imsk ? {29'h0, irq_mask} :
    rd_baud ? {16'h0000, baud_div_o} : 32'h00000000;

  // write address channel, reopened only after the response
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_awready_o <= 1'b1;
      aw_got          <= 1'b0;
      awaddr_q        <= 8'h00;
    end else if (aw_hs) begin
      s_axi_awready_o <= 1'b0;
      aw_got          <= 1'b1;
      awaddr_q        <= s_axi_awaddr_i;
    end else begin
      if (wr_fire) aw_got <= 1'b0;
      if (b_hs) s_axi_awready_o <= 1'b1;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_wready_o <= 1'b1;
      w_got          <= 1'b0;
      wdata_q        <= 32'h00000000;
      wstrb_q        <= 4'h0;
    end else if (w_hs) begin
      s_axi_wready_o <= 1'b0;
      w_got          <= 1'b1;
      wdata_q        <= s_axi_wdata_i;
      wstrb_q        <= s_axi_wstrb_i;
    end else begin
      if (wr_fire) w_got <= 1'b0;
      if (b_hs) s_axi_wready_o <= 1'b1;
    end
  end

  // write response, unmapped addresses answer slverr
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= scs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? scs_pkg::RESP_OKAY
                               : scs_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // read channel, one read in flight
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= scs_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_data;
      s_axi_rresp_o   <= rd_hit ? scs_pkg::RESP_OKAY
                                : scs_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

  // control register; input function wins a write asking for both
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      // R1: internal after reset
      ext_sel <= 1'b0;
      out_en  <= 1'b0;
      div_exp <= scs_pkg::DIV_EXP_RST;
    end else if (wr_ctrl) begin
      // R7: functions exclude each other
      ext_sel <= ctrl_new[scs_pkg::CTRL_EXT_BIT];
      // R9: output enable command
      out_en  <= ctrl_new[scs_pkg::CTRL_OUT_BIT] &
                 ~ctrl_new[scs_pkg::CTRL_EXT_BIT];
      div_exp <= ctrl_new[scs_pkg::CTRL_DIV_LSB +: DW];
    end
  end

  // frequency command, starts a divisor recomputation
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      freq_khz  <= scs_pkg::FREQ_RST;
      div_start <= 1'b0;
      irq_mask  <= '0;
    end else begin
      // R5: host reports ext frequency
      div_start <= wr_freq;
      if (wr_freq) freq_khz <= freq_new[FW-1:0];
      if (wr_imsk) irq_mask <= mask_new[IW-1:0];
    end
  end

  // R6: divisor from new frequency
  assign div_bus.start    = div_start;
  assign div_bus.dividend = 32'(freq_khz * scs_pkg::KHZ_HZ);
  assign div_bus.divisor  = 32'(scs_pkg::BAUD_RATE);

  // serial port divisor follows each finished calculation
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) baud_div_o <= scs_pkg::BAUD_RST;
    else if (div_bus.done) baud_div_o <= div_bus.quotient[15:0];
  end

  // sync pin synchroniser and edge history
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
      sync_q3 <= 1'b0;
    end else begin
      sync_q1 <= sync_i;
      sync_q2 <= sync_q1;
      sync_q3 <= sync_q2;
    end
  end

  // R10: own drive ignored as input
  wire ext_edge = ext_sel & sync_q2 & ~sync_q3;
  wire ext_good = good_cnt == GOOD_MAX;

  // R11: edge timeout watchdog
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !ext_sel || ext_edge) idle_cnt <= '0;
    else if (!ext_dead) idle_cnt <= idle_cnt + 1'b1;
  end

  // a dead source must show several edges before it is trusted again
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !ext_sel || ext_dead) good_cnt <= '0;
    else if (ext_edge && !ext_good) good_cnt <= good_cnt + 1'b1;
  end

  // source switch events
  wire go_ext   = (src == scs_pkg::SRC_INT) & ext_good & ext_edge;
  wire fallback = (src == scs_pkg::SRC_EXT) & ext_dead;

  // source selection, changes only at an edge, a clean timeout or when ext is deselected
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      src <= scs_pkg::SRC_INT;
    end else begin
      unique case (src)
        scs_pkg::SRC_INT: begin
          // R2: adopt ext on its edge
          if (go_ext) src <= scs_pkg::SRC_EXT;
        end
        scs_pkg::SRC_EXT: begin
          // R4: automatic fallback on failure
          if (!ext_sel || ext_dead) src <= scs_pkg::SRC_INT;
        end
      endcase
    end
  end

  // internal tick prescaler
  wire int_tick = tick_cnt == TICK_LAST;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || int_tick) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  // R3: one tick feeds both
  wire sel_tick = (src == scs_pkg::SRC_EXT) ? ext_edge : int_tick;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sup_tick_o    <= 1'b0;
      logic_tick_o  <= 1'b0;
      clk_src_ext_o <= 1'b0;
    end else begin
      sup_tick_o    <= sel_tick;
      logic_tick_o  <= sel_tick;
      clk_src_ext_o <= src == scs_pkg::SRC_EXT;
    end
  end

  // exponent zero is treated as one since a full-rate copy is impossible
  wire [CW-1:0] next_out_cnt = out_cnt + 1'b1;
  wire [DW-1:0] out_bit = (div_exp == '0) ? '0 : div_exp - 1'b1;
  // R7: no drive until the internal source is back in use
  wire drv_en = out_en & (src == scs_pkg::SRC_INT);

  // R8: divided internal clock out
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      out_cnt   <= '0;
      sync_o    <= 1'b0;
      sync_oe_o <= 1'b0;
    end else begin
      out_cnt   <= next_out_cnt;
      sync_o    <= drv_en & next_out_cnt[out_bit];
      // R10: drive line only when outputting
      sync_oe_o <= drv_en;
    end
  end

  // interrupt events
  wire [IW-1:0] irq_ev = {div_bus.done, go_ext, fallback};

  // sticky bits, a new event beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < IW; gi++) begin : g_irq
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) irq_stat[gi] <= 1'b0;
        else irq_stat[gi] <= irq_ev[gi] | (irq_stat[gi] & ~irq_clr[gi]);
      end
    end
  endgenerate

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) irq_o <= 1'b0;
    else irq_o <= |(irq_stat & irq_mask);
  end
endmodule
`default_nettype wire

// [testbench/scs_assertions.sv]
// concurrent checks on the ports of the sync clock select top
// assumes one reference clock and a synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module scs_chk #(
  parameter int TIMEOUT_CYC = 8
) (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  // read answer
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // sync line and pacing
  input wire logic        sync_i,
  input wire logic        sync_o,
  input wire logic        sync_oe_o,
  input wire logic        sup_tick_o,
  input wire logic        logic_tick_o,
  input wire logic        clk_src_ext_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic       sync_q; // pin level one cycle ago
  logic [7:0] quiet;  // cycles since the last rising level at the pin
  // counter saturates so a long idle line cannot wrap back to small
  always_ff @(posedge ref_clk_i) begin
    sync_q <= sync_i;
    if (!rst_b_i || (sync_i && !sync_q)) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  oe_excl_a: assert property (clk_src_ext_o |-> !sync_oe_o)
    else $error("sync line driven while on external clock");
  out_idle_a: assert property (!sync_oe_o |-> !sync_o)
    else $error("sync output moves while disabled");
  tick_pair_a: assert property (sup_tick_o == logic_tick_o)
    else $error("controller and logic ticks differ");
  // a tick never lasts two cycles, also across a source switch
  tick_pulse_a: assert property (sup_tick_o |=> !sup_tick_o)
    else $error("tick wider than one cycle");
  int_rate_a: assert property ((!clk_src_ext_o) [*4] ##0 sup_tick_o
    |=> !sup_tick_o ##1 (sup_tick_o || clk_src_ext_o))
    else $error("internal tick not every second cycle");
  // margin covers the two sync flops, edge detect and the switch
  fallback_a: assert property (quiet >= TIMEOUT_CYC + 8 |-> !clk_src_ext_o)
    else $error("external source kept after it stopped");
  ext_live_a: assert property ($rose(clk_src_ext_o)
    |-> quiet < TIMEOUT_CYC && !sync_oe_o)
    else $error("switched to external without live input");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer changed before taken");
endmodule
bind scs_top scs_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .ref_clk_i, .rst_b_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
  .sync_i, .sync_o, .sync_oe_o, .sup_tick_o, .logic_tick_o, .clk_src_ext_o
);
`default_nettype wire

// [testbench/scs_osc_model.sv]
// far side of the sync line: an external oscillator or another supervisor
// assumes the testbench starts, slows and stops the oscillator
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
  parameter int HALF_NS = 230,
  parameter int SLOW_NS = 300
) (
  // control from the testbench
  input  wire logic run_i,   // oscillate; low freezes the level
  input  wire logic drive_i, // model drives the shared line
  input  wire logic slow_i,  // longer half period
  // shared line
  input  wire logic dut_o_i,
  input  wire logic dut_oe_i,
  output logic      line_o
);
  logic osc = 1'b0; // oscillator level
  logic last = 1'b0; // level last driven onto the line
  // a failed source stops in place rather than going quiet cleanly
  always begin
    #(slow_i ? SLOW_NS : HALF_NS);
    if (run_i) osc = ~osc;
  end
  // a released line with no pull settles away from its last level
  always @* if (dut_oe_i || drive_i) last = dut_oe_i ? dut_o_i : osc;
  assign line_o = (dut_oe_i && drive_i) ? 1'bx :
                  dut_oe_i ? dut_o_i : drive_i ? osc : ~last;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the sync clock select top over AXI4-Lite
// assumes the oscillator model sits on the shared sync line
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TMO = 8; // shortened failure timeout
  // bus stimulus
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic        s_axi_awvalid_i = 1'b0;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic        run = 1'b0;
  logic        drive = 1'b0;
  logic        slow = 1'b0;
  // design outputs
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, sync_i, sync_o, sync_oe_o;
  logic        sup_tick_o, logic_tick_o, clk_src_ext_o, irq_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  logic [31:0] s_axi_rdata_o, v;
  logic [15:0] baud_div_o;
  int          n_fail = 0;
  int          n_tests = 0;
  int          c;
  scs_top #(.TIMEOUT_CYC(TMO), .LOCK_EDGES(2), .TICK_DIV(2)) u_dut (
    .ref_clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .sync_i, .sync_o, .sync_oe_o,
    .sup_tick_o, .logic_tick_o, .clk_src_ext_o, .baud_div_o, .irq_o);
  scs_osc_model u_osc (.run_i(run), .drive_i(drive), .slow_i(slow),
    .dut_o_i(sync_o), .dut_oe_i(sync_oe_o), .line_o(sync_i));
  // 10 MHz reference
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, e);
    n_tests++;
    if (seen !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!(s_axi_bvalid_o && s_axi_bready_i) && n < 50);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n >= 50) n_fail++;
  endtask
  // read: rready comes a cycle after rvalid, so the answer must stand
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
    end while (!(s_axi_rvalid_o && s_axi_rready_i) && n < 50);
    v = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (n >= 50) n_fail++;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), v, e);
    chk("rresp", r, 2'h0);
  endtask
  task automatic ticks(input int k);
    c = 0;
    repeat (k) begin
      @(posedge ref_clk_i);
      if (sup_tick_o === 1'b1) c++;
    end
  endtask
  // bounded wait for the source flag, c holds the cycles taken
  task automatic wait_src(input logic e);
    c = 0;
    while (clk_src_ext_o !== e && c < 60) begin
      @(posedge ref_clk_i);
      c++;
    end
    chk("src_ext", clk_src_ext_o, e);
  endtask
  // cycles between two rises of the driven sync output
  task automatic period;
    time t0;
    @(posedge sync_o);
    t0 = $time;
    @(posedge sync_o);
    c = int'(($time - t0) / 100);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog: the tests take a few hundred cycles
  initial begin
    #1_000_000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rchk(scs_pkg::ADDR_CTRL, 32'h10);
    rchk(scs_pkg::ADDR_FREQ, 32'h3E1C);
    rchk(scs_pkg::ADDR_IRQ_STAT, 32'h0);
    rchk(scs_pkg::ADDR_IRQ_MASK, 32'h0);
    rchk(scs_pkg::ADDR_BAUD, 32'h8A);
    chk("baud_div", baud_div_o, 32'h8A);
    ticks(20);
    chk("int_ticks", c, 10);
    wr(8'h18, 32'h1);
    chk("bresp_unmapped", r, 2'h2);
    rd(8'h18);
    chk("rdata_unmapped", v, 32'h0);
    chk("rresp_unmapped", r, 2'h2);
    wr(scs_pkg::ADDR_STAT, 32'h7);
    rchk(scs_pkg::ADDR_STAT, 32'h0);
    // exponents 0 to 3; zero behaves as one
    for (int e = 0; e < 4; e++) begin
      wr(scs_pkg::ADDR_CTRL, {24'h0, 4'(e), 4'h2});
      ticks(1);
      chk("sync_oe", sync_oe_o, 1);
      period();
      period();
      chk("out_period", c, (e == 0) ? 2 : (1 << e));
    end
    wr(scs_pkg::ADDR_CTRL, 32'h13);
    rchk(scs_pkg::ADDR_CTRL, 32'h11);
    chk("oe_off", sync_oe_o, 0);
    drive <= 1'b1;
    run <= 1'b1;
    slow <= 1'b1;
    wait_src(1'b1);
    ticks(60);
    chk("slow_ticks", c >= 9 && c <= 11, 1);
    slow <= 1'b0;
    ticks(46);
    chk("ext_ticks", c >= 9 && c <= 11, 1);
    rchk(scs_pkg::ADDR_STAT, 32'h1);
    run <= 1'b0;
    ticks(3);
    chk("src_hold", clk_src_ext_o, 1);
    wait_src(1'b0);
    chk("fall_time", c <= TMO + 4, 1);
    rchk(scs_pkg::ADDR_STAT, 32'h2);
    rchk(scs_pkg::ADDR_IRQ_STAT, 32'h3);
    chk("irq_masked", irq_o, 0);
    wr(scs_pkg::ADDR_IRQ_MASK, 32'h1);
    ticks(2);
    chk("irq_on", irq_o, 1);
    wr(scs_pkg::ADDR_IRQ_STAT, 32'h3);
    ticks(2);
    chk("irq_off", irq_o, 0);
    run <= 1'b1;
    wait_src(1'b1);
    drive <= 1'b0;
    wr(scs_pkg::ADDR_CTRL, 32'h12);
    ticks(3);
    chk("src_ext", clk_src_ext_o, 0);
    chk("sync_oe", sync_oe_o, 1);
    rchk(scs_pkg::ADDR_IRQ_STAT, 32'h2);
    chk("irq_quiet", irq_o, 0);
    // commanded frequency 8000 kHz; busy bit polled under a bound
    wr(scs_pkg::ADDR_FREQ, 32'h1F40);
    c = 0;
    do begin
      rd(scs_pkg::ADDR_STAT);
      c++;
    end while (v[2] !== 1'b0 && c < 30);
    rchk(scs_pkg::ADDR_BAUD, 32'h45);
    chk("baud_div", baud_div_o, 32'h45);
    rchk(scs_pkg::ADDR_IRQ_STAT, 32'h6);
    wrap_up();
  end
endmodule
`default_nettype wire
